// >>> design/sffc_top.sv
// Purpose: Serial frame mode register, transmit frame composer and receive frame checker.
// Assumes: All inputs synchronous to ref_clk_i; shifters and baud generator sit outside.
// Notes: A 16-word buffer holds transmit characters between software and the composer.
// Contract
// - Mode register is 8 bits, read and written by software any time.
// - Mode register clears to zero on reset and on any standby mode.
// - Bit 7 picks asynchronous (0) or clocked synchronous (1) operation.
// - Bit 6 picks 8 or 7 data bits asynchronously; synchronous is 8.
// - With 7-bit characters, data bit 7 is not transmitted.
// - Five-bit characters need parity enable and five-bit bits; bits 7..5 dropped. Here bit 2 alone selects five-bit, parity or not.
// - Bit 5 adds and checks parity asynchronously; never in synchronous mode.
// - Bit 4 picks even (0) or odd (1) parity, only when parity active.
// - Parity makes ones over data plus parity odd or even; checked likewise.
// - Bit 3 gives one or two stop bits asynchronously; none synchronously.
// - Receiver checks only the first stop bit.
// - Low second bit after first stop starts next character; high is stop.
// - Bit 2 set enables five-bit format; clear keeps 7/8 by bit 6.
// - Bits 1..0 pick baud source: sys, sub/2, sys/16, sys/64.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module sffc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
    localparam logic [AW:0] LEVEL_ONE = (AW+1)'(1);
    localparam logic [AW-1:0] PTR_ONE = AW'(1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] level_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    // Full and empty follow the level count directly.
    assign in_ready_o = (level_q != FULL_LEVEL);
    assign out_valid_o = (level_q != '0);
    assign out_data_o = mem_q[rd_ptr_q];
    assign level_o = level_q;

    // Storage array, written only on an accepted push.
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // Pointers and level; a flush empties the buffer like a reset.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || flush_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + PTR_ONE;
            if (pop)
                rd_ptr_q <= rd_ptr_q + PTR_ONE;
            if (push && !pop)
                level_q <= level_q + LEVEL_ONE;
            else if (pop && !push)
                level_q <= level_q - LEVEL_ONE;
        end
    end

    property p_no_push_full;
        @(posedge clk_i) disable iff (rst_i)
        (level_q == FULL_LEVEL) && !pop && !flush_i |=> level_q == FULL_LEVEL;
    endproperty
    a_no_push_full: assert property (p_no_push_full) else $error("Buffer level moved past full.");

endmodule : sffc_fifo

module sffc_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic standby_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic sync_mode_o,
    output sffc_pkg::sffc_baud_e baud_src_o,
    output logic tx_frame_valid_o,
    output sffc_pkg::sffc_txframe_s tx_frame_o,
    input wire logic tx_frame_ready_i,
    input wire logic rx_frame_valid_i,
    input wire sffc_pkg::sffc_rxframe_s rx_frame_i,
    output logic rx_check_valid_o,
    output logic rx_parity_err_o,
    output logic rx_framing_err_o,
    output logic rx_next_start_o
);
    sffc_pkg::sffc_mode_s mode_q;
    sffc_pkg::sffc_txframe_s txf_q;
    sffc_pkg::sffc_txframe_s txf_d;
    logic txv_q;
    logic [7:0] rdata_q;
    logic perr_flag_q;
    logic ferr_flag_q;
    logic chk_v_q;
    logic perr_q;
    logic ferr_q;
    logic nstart_q;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_in_ready;
    logic [4:0] fifo_level;

    // Address decode of the register port.
    wire sel_mode = (reg_addr_i == sffc_pkg::ADDR_MODE);
    wire sel_txdata = (reg_addr_i == sffc_pkg::ADDR_TXDATA);
    wire sel_status = (reg_addr_i == sffc_pkg::ADDR_STATUS);
    wire sel_rxflag = (reg_addr_i == sffc_pkg::ADDR_RXFLAG);
    wire wr_mode = reg_wr_i && sel_mode;
    wire wr_rxflag = reg_wr_i && sel_rxflag;

    // Effective character format; synchronous mode forces plain 8-bit data.
    wire async_mode = !mode_q.sync_mode;
    wire use_five = async_mode && mode_q.five_bit_format;
    wire use_seven = async_mode && !use_five && mode_q.char_len_seven;
    wire use_parity = async_mode && mode_q.parity_enable;
    wire odd_sel = use_parity && mode_q.parity_odd_select;
    wire use_two_stop = async_mode && mode_q.two_stop;
    wire [3:0] char_len = use_five ? sffc_pkg::LEN_FIVE : (use_seven ? sffc_pkg::LEN_SEVEN : sffc_pkg::LEN_EIGHT);
    wire [7:0] char_mask = use_five ? sffc_pkg::MASK_FIVE
        : (use_seven ? sffc_pkg::MASK_SEVEN : sffc_pkg::MASK_EIGHT);

    assign sync_mode_o = mode_q.sync_mode;
    assign baud_src_o = sffc_pkg::sffc_baud_e'({mode_q.baud_source_select_hi, mode_q.baud_source_select_lo});

    // Register read mux; unmapped offsets read as zero.
    wire [7:0] status_word = {!fifo_in_ready, !fifo_valid, 1'b0, fifo_level};
    wire [7:0] rxflag_word = {6'h00, ferr_flag_q, perr_flag_q};
    wire [7:0] rd_word = sel_mode ? mode_q
        : sel_status ? status_word
        : sel_rxflag ? rxflag_word
        : sffc_pkg::READ_ZERO;

    // Mode register; standby clears it and wins over a write in the same cycle.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || standby_i)
            mode_q <= sffc_pkg::MODE_RESET;
        else if (wr_mode)
            mode_q <= reg_wdata_i;
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            rdata_q <= sffc_pkg::READ_ZERO;
        else
            rdata_q <= reg_rd_i ? rd_word : sffc_pkg::READ_ZERO;
    end
    assign reg_rdata_o = rdata_q;

    // Software pushes characters; a write to a full buffer is dropped and shows in status.
    sffc_fifo #(
        .WIDTH(sffc_pkg::FIFO_WIDTH),
        .DEPTH(sffc_pkg::FIFO_DEPTH)
    ) u_txbuf (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .flush_i(standby_i),
        .in_valid_i(reg_wr_i && sel_txdata),
        .in_data_i(reg_wdata_i),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(!txv_q || tx_frame_ready_i),
        .level_o(fifo_level)
    );

    // Frame composition: start, masked data, optional parity, stop ones.
    // Extra ones above nbits are harmless because the shifter stops at nbits.
    wire pop = fifo_valid && (!txv_q || tx_frame_ready_i);
    wire [7:0] tx_data = fifo_data & char_mask;
    wire tx_par = (^tx_data) ^ odd_sel;
    wire [2:0] tail = use_parity ? {sffc_pkg::STOP_LEVEL, sffc_pkg::STOP_LEVEL, tx_par}
        : {3{sffc_pkg::STOP_LEVEL}};
    wire [10:0] payload = {3'h0, tx_data} | (11'(tail) << char_len);
    wire [3:0] stop_cnt = use_two_stop ? 4'h2 : sffc_pkg::ONE_BIT;
    wire [3:0] par_cnt = use_parity ? sffc_pkg::ONE_BIT : 4'h0;
    always_comb
    begin
        if (async_mode)
        begin
            txf_d.bits = {payload, sffc_pkg::START_LEVEL};
            txf_d.nbits = sffc_pkg::ONE_BIT + char_len + par_cnt + stop_cnt;
        end
        else
        begin
            txf_d.bits = {4'h0, fifo_data};
            txf_d.nbits = sffc_pkg::LEN_EIGHT;
        end
    end

    // Output stage holds a frame until the shifter takes it.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || standby_i)
        begin
            txv_q <= 1'b0;
            txf_q <= '0;
        end
        else if (pop)
        begin
            txv_q <= 1'b1;
            txf_q <= txf_d;
        end
        else if (tx_frame_ready_i)
            txv_q <= 1'b0;
    end
    assign tx_frame_valid_o = txv_q;
    assign tx_frame_o = txf_q;

    // Receive checks; only the first stop bit can raise a framing error.
    wire [7:0] rx_data = rx_frame_i.data & char_mask;
    wire rx_perr = use_parity && ((^{rx_data, rx_frame_i.parity}) != odd_sel);
    wire rx_ferr = async_mode && !rx_frame_i.stop_first;
    wire rx_nstart = async_mode && rx_frame_i.stop_first && !rx_frame_i.stop_second;

    // One-cycle check results after each delivered character.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            chk_v_q <= 1'b0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            nstart_q <= 1'b0;
        end
        else
        begin
            chk_v_q <= rx_frame_valid_i;
            perr_q <= rx_frame_valid_i && rx_perr;
            ferr_q <= rx_frame_valid_i && rx_ferr;
            nstart_q <= rx_frame_valid_i && rx_nstart;
        end
    end
    assign rx_check_valid_o = chk_v_q;
    assign rx_parity_err_o = perr_q;
    assign rx_framing_err_o = ferr_q;
    assign rx_next_start_o = nstart_q;

    // Sticky error flags, write one to clear; a new error in the clearing cycle wins.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            perr_flag_q <= 1'b0;
            ferr_flag_q <= 1'b0;
        end
        else
        begin
            perr_flag_q <= (rx_frame_valid_i && rx_perr) || (perr_flag_q && !(wr_rxflag && reg_wdata_i[0]));
            ferr_flag_q <= (rx_frame_valid_i && rx_ferr) || (ferr_flag_q && !(wr_rxflag && reg_wdata_i[1]));
        end
    end

    property p_mode_reset;
        @(posedge ref_clk_i) (rst_i || standby_i) |=> mode_q == sffc_pkg::MODE_RESET;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("Mode register not cleared.");

    property p_mode_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_mode && !standby_i |=> mode_q == $past(reg_wdata_i);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("Mode write not stored.");

    property p_mode_read;
        @(posedge ref_clk_i) disable iff (rst_i)
        reg_rd_i && sel_mode |=> reg_rdata_o == $past(mode_q) ##1 reg_rdata_o == 8'h00 || $past(reg_rd_i);
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("Mode read data wrong.");

    property p_sync_frame;
        @(posedge ref_clk_i) disable iff (rst_i || standby_i)
        pop && mode_q.sync_mode |=> tx_frame_o.nbits == sffc_pkg::LEN_EIGHT && tx_frame_o.bits[7:0] == $past(fifo_data);
    endproperty
    a_sync_frame: assert property (p_sync_frame) else $error("Synchronous frame not plain 8 bits.");

    property p_seven_len;
        @(posedge ref_clk_i) disable iff (rst_i || standby_i)
        pop && async_mode && mode_q.char_len_seven && !mode_q.five_bit_format && !mode_q.parity_enable
        && !mode_q.two_stop |=> tx_frame_o.nbits == 4'h9 && tx_frame_o.bits[8] == sffc_pkg::STOP_LEVEL;
    endproperty
    a_seven_len: assert property (p_seven_len) else $error("Seven-bit frame length wrong.");

    property p_two_stop;
        @(posedge ref_clk_i) disable iff (rst_i || standby_i)
        pop && async_mode && mode_q.two_stop && !mode_q.parity_enable && !mode_q.char_len_seven
        && !mode_q.five_bit_format |=> tx_frame_o.nbits == 4'hb && tx_frame_o.bits[10:9] == 2'h3;
    endproperty
    a_two_stop: assert property (p_two_stop) else $error("Two stop bits not appended.");

    property p_tx_parity;
        @(posedge ref_clk_i) disable iff (rst_i || standby_i)
        pop && use_parity && !use_five && !use_seven
        |=> (^tx_frame_o.bits[9:1]) == $past(mode_q.parity_odd_select);
    endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("Transmit parity sense wrong.");

    property p_sync_no_err;
        @(posedge ref_clk_i) disable iff (rst_i)
        rx_frame_valid_i && mode_q.sync_mode |=> !rx_parity_err_o && !rx_framing_err_o && rx_check_valid_o;
    endproperty
    a_sync_no_err: assert property (p_sync_no_err) else $error("Error raised in synchronous mode.");

    property p_first_stop;
        @(posedge ref_clk_i) disable iff (rst_i)
        rx_frame_valid_i && async_mode |=> rx_framing_err_o == !$past(rx_frame_i.stop_first);
    endproperty
    a_first_stop: assert property (p_first_stop) else $error("Framing check not on first stop.");

    property p_next_start;
        @(posedge ref_clk_i) disable iff (rst_i)
        rx_frame_valid_i && async_mode && rx_frame_i.stop_first && !rx_frame_i.stop_second
        |=> rx_next_start_o && !rx_framing_err_o;
    endproperty
    a_next_start: assert property (p_next_start) else $error("Low second bit not taken as start.");

endmodule : sffc_top

// >>> design/sffc_pkg.sv
// Purpose: Shared constants and types for the serial frame format configuration block.
// Assumes: Plain register port with 4-bit address and 8-bit data.
// Notes: Register offsets below are local to this block.
package sffc_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_TXDATA = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_RXFLAG = 4'h3;

    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Transmit buffer shape.
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    // Character lengths and frame shape.
    localparam logic [3:0] LEN_EIGHT = 4'h8;
    localparam logic [3:0] LEN_SEVEN = 4'h7;
    localparam logic [3:0] LEN_FIVE = 4'h5;
    localparam logic [3:0] ONE_BIT = 4'h1;
    localparam logic [7:0] MASK_EIGHT = 8'hff;
    localparam logic [7:0] MASK_SEVEN = 8'h7f;
    localparam logic [7:0] MASK_FIVE = 8'h1f;
    localparam logic START_LEVEL = 1'b0;
    localparam logic STOP_LEVEL = 1'b1;

    // Mode register layout, most significant field first.
    typedef struct packed {
        logic sync_mode;
        logic char_len_seven;
        logic parity_enable;
        logic parity_odd_select;
        logic two_stop;
        logic five_bit_format;
        logic baud_source_select_hi;
        logic baud_source_select_lo;
    } sffc_mode_s;

    typedef enum logic [1:0] {
        SFFC_BAUD_SYS,
        SFFC_BAUD_SUB_DIV2,
        SFFC_BAUD_SYS_DIV16,
        SFFC_BAUD_SYS_DIV64
    } sffc_baud_e;

    // One composed transmit frame, first bit on the line in bit 0.
    typedef struct packed {
        logic [11:0] bits;
        logic [3:0] nbits;
    } sffc_txframe_s;

    // One received character as delivered by the receive shifter.
    typedef struct packed {
        logic [7:0] data;
        logic parity;
        logic stop_first;
        logic stop_second;
    } sffc_rxframe_s;

endpackage : sffc_pkg

// >>> sim/sffc_partner.sv
// Purpose: Far-side transmit shifter model that accepts composed frames.
// Assumes: One clock; a frame is taken at an edge where valid and ready are both high.
// Notes: Stalling holds ready low, so the buffer in the block can be seen filling up.
`timescale 1ns/1ps

module sffc_partner (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic tx_frame_valid_i,
    input wire sffc_pkg::sffc_txframe_s tx_frame_i,
    output logic tx_frame_ready_o,
    output sffc_pkg::sffc_txframe_s last_frame_o,
    output logic [7:0] count_o
);
    // A real shifter is busy while it sends, which is what the stall stands for.
    assign tx_frame_ready_o = ~stall_i;

    // Each accepted frame is kept for the bench and counted.
    initial count_o = 8'h00;
    always @(posedge clk_i)
    begin
        if (tx_frame_valid_i && tx_frame_ready_o)
        begin
            last_frame_o <= tx_frame_i;
            count_o <= count_o + 8'h01;
        end
    end
endmodule : sffc_partner

// >>> sim/test_serial_frame_format_config.sv
// Purpose: Self-checking bench for the frame mode register, frame composer and receive checker.
// Assumes: Register port answers reads in the cycle after the strobe.
// Notes: Frame bits above the frame length are not compared, since they carry no meaning.
`timescale 1ns/1ps

module test_serial_frame_format_config;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic stby = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic sync_mode;
    sffc_pkg::sffc_baud_e baud;
    logic txv;
    logic txr;
    sffc_pkg::sffc_txframe_s txf;
    sffc_pkg::sffc_txframe_s got;
    logic [7:0] cnt;
    logic stall = 1'b0;
    logic rxv = 1'b0;
    sffc_pkg::sffc_rxframe_s rxf = '0;
    logic [3:0] rxo;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    logic [7:0] rd_val;
    logic [15:0] ef;
    logic [11:0] msk;
    logic [7:0] c0;
    logic [7:0] dm;
    logic [7:0] mode_byte;
    logic [7:0] tx_char;
    // Ordinary cases, one row each: mode byte, character, expected frame bits and length, then the
    // expected check pulses {valid, parity, framing, next start} for the good and for the bad character.
    logic [39:0] rows [6] = '{40'h00a5f4aa9a, 40'h41ffffe99a, 40'h26ffffe89e,
                              40'h3b03e06c9e, 40'h2007e0eb9e, 40'hf85af5a888};

    sffc_top sffc_top_inst (.ref_clk_i(clk), .rst_i(rst), .standby_i(stby), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sync_mode_o(sync_mode),
        .baud_src_o(baud), .tx_frame_valid_o(txv), .tx_frame_o(txf), .tx_frame_ready_i(txr),
        .rx_frame_valid_i(rxv), .rx_frame_i(rxf), .rx_check_valid_o(rxo[3]), .rx_parity_err_o(rxo[2]),
        .rx_framing_err_o(rxo[1]), .rx_next_start_o(rxo[0]));
    sffc_partner sffc_partner_inst (.clk_i(clk), .stall_i(stall), .tx_frame_valid_i(txv),
        .tx_frame_i(txf), .tx_frame_ready_o(txr), .last_frame_o(got), .count_o(cnt));

    // Clock at 20 MHz and a cycle ceiling that cuts a hang short.
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rreg(sffc_pkg::ADDR_MODE, rd_val);
        chk("mode after reset", 16'h0000, {8'h00, rd_val});
        // Table loop: mode readback, decoded outputs, composed frame and receive checks.
        for (int r = 0; r < 6; r++)
        begin
            mode_byte = rows[r][39:32];
            tx_char = rows[r][31:24];
            ef = rows[r][23:8];
            wreg(sffc_pkg::ADDR_MODE, mode_byte);
            rreg(sffc_pkg::ADDR_MODE, rd_val);
            chk("mode readback", {8'h00, mode_byte}, {8'h00, rd_val});
            chk("sync mode", {15'h0, mode_byte[7]}, {15'h0, sync_mode});
            chk("baud source", {14'h0, mode_byte[1:0]}, {14'h0, baud});
            c0 = cnt;
            wreg(sffc_pkg::ADDR_TXDATA, tx_char);
            for (int w = 0; w < 20 && cnt == c0; w++)
                @(posedge clk);
            msk = (12'h001 << ef[3:0]) - 12'h001;
            chk("frame length", {12'h0, ef[3:0]}, {12'h0, got.nbits});
            chk("frame bits", {4'h0, ef[15:4] & msk}, {4'h0, got.bits & msk});
            // Good character then one with bad parity and a low first stop, back to back.
            dm = tx_char & (mode_byte[2] ? 8'h1f : (mode_byte[6] ? 8'h7f : 8'hff));
            @(posedge clk);
            rxv <= 1'b1;
            rxf <= {tx_char, mode_byte[4] ^ (^dm), 1'b1, 1'b0};
            @(posedge clk);
            rxf <= {tx_char, ~(mode_byte[4] ^ (^dm)), 1'b0, 1'b0};
            #1 chk("rx good", {12'h0, rows[r][7:4]}, {12'h0, rxo});
            @(posedge clk);
            rxv <= 1'b0;
            #1 chk("rx bad", {12'h0, rows[r][3:0]}, {12'h0, rxo});
        end
        // A second high stop bit is a stop, not the start of another character.
        wreg(sffc_pkg::ADDR_MODE, 8'h08);
        @(posedge clk);
        rxv <= 1'b1;
        rxf <= {8'h12, 1'b0, 1'b1, 1'b1};
        @(posedge clk);
        rxv <= 1'b0;
        #1 chk("rx high second", 16'h0008, {12'h0, rxo});
        // Sticky receive flags; a clear in the same cycle as a new framing error loses to it.
        rreg(sffc_pkg::ADDR_RXFLAG, rd_val);
        chk("rx flags set", 16'h0003, {8'h00, rd_val});
        @(posedge clk);
        addr <= sffc_pkg::ADDR_RXFLAG;
        wdata <= 8'h03;
        wr <= 1'b1;
        rxv <= 1'b1;
        rxf <= {8'h12, 1'b0, 1'b0, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
        rxv <= 1'b0;
        rreg(sffc_pkg::ADDR_RXFLAG, rd_val);
        chk("rx flags clear race", 16'h0002, {8'h00, rd_val});
        wreg(sffc_pkg::ADDR_RXFLAG, 8'h03);
        rreg(sffc_pkg::ADDR_RXFLAG, rd_val);
        chk("rx flags cleared", 16'h0000, {8'h00, rd_val});
        // Standby clears the mode and a write during it is ignored.
        wreg(sffc_pkg::ADDR_MODE, 8'h3b);
        @(posedge clk);
        stby <= 1'b1;
        wreg(sffc_pkg::ADDR_MODE, 8'h55);
        stby <= 1'b0;
        rreg(sffc_pkg::ADDR_MODE, rd_val);
        chk("mode after standby", 16'h0000, {8'h00, rd_val});
        // Fill the buffer while the shifter stalls; the push after full is dropped.
        @(posedge clk);
        stall <= 1'b1;
        c0 = cnt;
        for (int i = 0; i < 18; i++)
            wreg(sffc_pkg::ADDR_TXDATA, i[7:0]);
        rreg(sffc_pkg::ADDR_STATUS, rd_val);
        chk("status full", 16'h0001, {15'h0, rd_val[7]});
        @(posedge clk);
        stall <= 1'b0;
        repeat (40) @(posedge clk);
        chk("frames drained", 16'd17, {8'h00, cnt - c0});
        chk("last drained", 16'h0010, {8'h00, got.bits[8:1]});
        rreg(sffc_pkg::ADDR_STATUS, rd_val);
        chk("status empty", 16'h0040, {8'h00, rd_val});
        rreg(sffc_pkg::ADDR_TXDATA, rd_val);
        chk("txdata read", 16'h0000, {8'h00, rd_val});
        rreg(4'hf, rd_val);
        chk("unmapped read", 16'h0000, {8'h00, rd_val});
        print_verdict();
    end
endmodule : test_serial_frame_format_config
